// [tb/cmm_host_model.sv]
// host model: acknowledges interrupts with a status read
`timescale 1ns/10ps
module cmm_host_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic irq,
  input wire logic ackEn,
  input wire logic [3:0] ackDelay,
  output logic statusRead
);
  logic [3:0] waitCnt_ff;
  // status is read ackDelay cycles after irq stands high, while ackEn is set
  always @(negedge mclk or negedge rstn) begin
    if (!rstn) begin
      statusRead <= 1'b0;
      waitCnt_ff <= 4'h0;
    end else begin
      statusRead <= 1'b0;
      if (ackEn && irq === 1'b1 && !statusRead) begin
        if (waitCnt_ff == ackDelay) begin
          statusRead <= 1'b1;
          waitCnt_ff <= 4'h0;
        end else begin
          waitCnt_ff <= waitCnt_ff + 4'h1;
        end
      end else begin
        waitCnt_ff <= 4'h0;
      end
    end
  end
endmodule // cmm_host_model

// [tb/test_cell_monitor_mode_control.sv]
// testbench: mode sequencing, acquisition and interrupt scenarios
`timescale 1ns/10ps
module test_cell_monitor_mode_control;
  import cmm_pkg::*;
  localparam int UP = 8;
  localparam int DN = 8;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic pin = 1'b0;
  logic ce = 1'b1;
  logic regEn = 1'b0;
  logic acqReq = 1'b0;
  logic convDone = 1'b0;
  logic filtDone = 1'b0;
  logic tAct = 1'b0;
  logic tRst = 1'b0;
  logic tWe = 1'b0;
  logic ackEn = 1'b0;
  logic [3:0] ackDelay = 4'h0;
  logic [TMR_W-1:0] tPer = 16'h0000;
  logic statusRead, chainOut, anaEn, digEn, mcuEn, cfgLoad, active;
  logic convStart, filterRun, dataReady, irq;
  int nMismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int nConv = 0;
  int nLoad = 0;

  always #2.5 mclk = ~mclk;

  cmm_mode_control #(.PWR_UP_CYC(UP), .PWR_DN_CYC(DN)) dut (
    .mclk(mclk), .rstn(rstn), .clkEn(ce),
    .sleepControlIn(pin), .mcuRegulatorEnable(regEn),
    .acqReq(acqReq), .convDone(convDone), .filtDone(filtDone),
    .statusRead(statusRead), .timerActivate(tAct),
    .timerRestart(tRst), .timerPeriodWe(tWe), .timerPeriod(tPer),
    .sleepControlChainOut(chainOut), .analogInternalSupplyEn(anaEn),
    .digitalInternalSupplyEn(digEn), .mcuSupplyOutEn(mcuEn),
    .cfgDefaultLoad(cfgLoad), .activeMode(active),
    .convStart(convStart), .filterRun(filterRun),
    .dataReady(dataReady), .irq(irq)
  );

  cmm_host_model host (
    .mclk(mclk), .rstn(rstn), .irq(irq), .ackEn(ackEn),
    .ackDelay(ackDelay), .statusRead(statusRead)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic checkInt(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      nMismatch++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic waitFor(input string what, ref logic s, input logic v,
                         input int lim);
    for (int i = 0; i < lim && s !== v; i++) begin
      @(negedge mclk);
    end
    check(what, v, s);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic wakeUp();
    pin = 1'b1;
    waitFor("analog supply", anaEn, 1'b1, 6);
    check("digital supply", 1'b1, digEn);
    check("mcu supply", regEn, mcuEn);
    waitFor("active mode", active, 1'b1, UP + 6);
    check("chain out high", 1'b1, chainOut);
  endtask

  task automatic scenRegulator();
    regEn = 1'b1;
    waitFor("mcu supply on", mcuEn, 1'b1, 5);
    regEn = 1'b0;
    waitFor("mcu supply off", mcuEn, 1'b0, 5);
  endtask

  task automatic scenAcq();
    int n0;
    n0 = nConv;
    pulse(acqReq);
    @(negedge mclk);
    check("filter running", 1'b1, filterRun);
    pulse(acqReq);
    repeat (2) @(negedge mclk);
    checkInt("conversion starts", n0 + 1, nConv);
    pulse(filtDone);
    @(negedge mclk);
    check("ready waits for both", 1'b0, dataReady);
    pulse(convDone);
    waitFor("data ready", dataReady, 1'b1, 3);
    check("irq on ready", 1'b1, irq);
    check("filter ended", 1'b0, filterRun);
    repeat (20) @(negedge mclk);
    check("irq held", 1'b1, irq);
    ackEn = 1'b1;
    waitFor("irq after ack", irq, 1'b0, 6);
    check("ready cleared", 1'b0, dataReady);
    ackEn = 1'b0;
  endtask

  // clock enable low: a dropped pin must not be seen while frozen
  task automatic scenFreeze();
    ce = 1'b0;
    pin = 1'b0;
    repeat (6) @(negedge mclk);
    check("frozen active", 1'b1, active);
    check("frozen chain", 1'b1, chainOut);
    pin = 1'b1;
    ce = 1'b1;
    repeat (4) @(negedge mclk);
    check("active after freeze", 1'b1, active);
  endtask

  task automatic scenTimer();
    tPer = 16'h0004;
    pulse(tWe);
    pulse(tAct);
    waitFor("timer irq", irq, 1'b1, 12);
    check("irq not from data", 1'b0, dataReady);
    ackDelay = 4'h5;
    ackEn = 1'b1;
    tPer = 16'h00C8;
    pulse(tWe);
    pulse(tRst);
    waitFor("timer acked", irq, 1'b0, 12);
    ackEn = 1'b0;
    repeat (150) @(negedge mclk);
    check("quiet after reprogram", 1'b0, irq);
    waitFor("timer ticks again", irq, 1'b1, 80);
  endtask

  task automatic scenSleep();
    pin = 1'b0;
    waitFor("active off", active, 1'b0, 6);
    waitFor("analog off", anaEn, 1'b0, 3);
    waitFor("digital off", digEn, 1'b0, DN + 6);
    check("irq off in sleep", 1'b0, irq);
    check("chain out low", 1'b0, chainOut);
  endtask

  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (convStart === 1'b1) nConv++;
    if (cfgLoad === 1'b1) nLoad++;
    if (cyc == 3000) begin
      nMismatch++;
      finalReport();
    end
  end

  initial begin
    repeat (10) @(negedge mclk);
    check("supply off in reset", 1'b0, anaEn);
    check("active off in reset", 1'b0, active);
    rstn = 1'b1;
    repeat (2) @(negedge mclk);
    wakeUp();
    scenRegulator();
    scenAcq();
    scenFreeze();
    scenTimer();
    scenSleep();
    wakeUp();
    checkInt("default loads", 2, nLoad);
    finalReport();
  end
endmodule // test_cell_monitor_mode_control

// [verilog/cmm_mode_control.sv]
// mode control: sleep/active sequencing, acquisition and interrupt
//
// Overview of operation
// - sleep keeps every internal block switched off
// - active while sleep control input is high
// - chained output passes mode to lower chip
// - low to high on input starts wake-up
// - supplies on; mcu supply only if enabled
// - every wake-up loads default configuration
// - acquisition converts all cells plus temperature
// - samples filtered before results count as ready
// - conversion and filtering done raise data-ready
// - status read acknowledges pending interrupt
// - pending interrupt drives irq high
// - wake timer periodically interrupts once activated
// - timer reprogrammable and resettable, stopped only by leaving active mode
// - sleep to active within 3 ms
// - active to sleep within 10 ms
`timescale 1ns/10ps
module cmm_mode_control
  import cmm_pkg::*;
#(
  parameter int unsigned PWR_UP_CYC = WAKE_CYC,
  parameter int unsigned PWR_DN_CYC = SLEEP_CYC
)(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic sleepControlIn,
  input wire logic mcuRegulatorEnable,
  input wire logic acqReq,
  input wire logic convDone,
  input wire logic filtDone,
  input wire logic statusRead,
  input wire logic timerActivate,
  input wire logic timerRestart,
  input wire logic timerPeriodWe,
  input wire logic [TMR_W-1:0] timerPeriod,
  output logic sleepControlChainOut,
  output logic analogInternalSupplyEn,
  output logic digitalInternalSupplyEn,
  output logic mcuSupplyOutEn,
  output logic cfgDefaultLoad,
  output logic activeMode,
  output logic convStart,
  output logic filterRun,
  output logic dataReady,
  output logic irq
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic sleepS1_ff, sleepS2_ff, regEnS1_ff, regEnS2_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sleepS1_ff <= 1'b0;
      sleepS2_ff <= 1'b0;
      regEnS1_ff <= 1'b0;
      regEnS2_ff <= 1'b0;
    end else if (clkEn) begin
      sleepS1_ff <= sleepControlIn;
      sleepS2_ff <= sleepS1_ff;
      regEnS1_ff <= mcuRegulatorEnable;
      regEnS2_ff <= regEnS1_ff;
    end
  end

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  cmm_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic cntDone;

  always_comb begin
    cntDone = 1'b0;
    case (state_ff)
      ST_PWRUP: cntDone = cnt_ff == CNT_W'(PWR_UP_CYC - 1);
      ST_PWRDN: cntDone = cnt_ff == CNT_W'(PWR_DN_CYC - 1);
      default: cntDone = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_SLEEP: if (sleepS2_ff) nxt_state = ST_PWRUP;
      ST_PWRUP: begin
        if (!sleepS2_ff) nxt_state = ST_PWRDN;
        else if (cntDone) nxt_state = ST_LOAD;
      end
      ST_LOAD: begin
        if (!sleepS2_ff) nxt_state = ST_PWRDN;
        else nxt_state = ST_ACTIVE;
      end
      ST_ACTIVE: if (!sleepS2_ff) nxt_state = ST_PWRDN;
      ST_PWRDN: if (cntDone) nxt_state = ST_SLEEP;
      default: nxt_state = ST_SLEEP;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_SLEEP;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else if (clkEn) begin
      if (nxt_state != state_ff) cnt_ff <= '0;
      else if (!cntDone) cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // supplies, chain output and mode outputs
  // ---------------------------------------------------------------
  logic nxtOn;
  assign nxtOn = nxt_state == ST_PWRUP || nxt_state == ST_LOAD ||
                 nxt_state == ST_ACTIVE;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sleepControlChainOut <= 1'b0;
      analogInternalSupplyEn <= 1'b0;
      digitalInternalSupplyEn <= 1'b0;
      mcuSupplyOutEn <= 1'b0;
      cfgDefaultLoad <= 1'b0;
      activeMode <= 1'b0;
    end else if (clkEn) begin
      sleepControlChainOut <= sleepS2_ff;
      analogInternalSupplyEn <= nxtOn;
      // digital supply stays up through the power-down ramp
      digitalInternalSupplyEn <= nxtOn || nxt_state == ST_PWRDN;
      mcuSupplyOutEn <= nxtOn && regEnS2_ff;
      cfgDefaultLoad <= nxt_state == ST_LOAD;
      activeMode <= nxt_state == ST_ACTIVE;
    end
  end

  // ---------------------------------------------------------------
  // acquisition: convert, filter, then data ready
  // ---------------------------------------------------------------
  logic acqBusy_ff, convSeen_ff, filtSeen_ff, runOk, acqGo, acqEnd;
  assign runOk = state_ff == ST_ACTIVE && nxt_state == ST_ACTIVE;
  assign acqGo = runOk && acqReq && !acqBusy_ff;
  assign acqEnd = runOk && acqBusy_ff && (convSeen_ff || convDone) &&
                  (filtSeen_ff || filtDone);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acqBusy_ff <= 1'b0;
      convSeen_ff <= 1'b0;
      filtSeen_ff <= 1'b0;
      convStart <= 1'b0;
      filterRun <= 1'b0;
    end else if (clkEn) begin
      convStart <= acqGo;
      if (!runOk || acqEnd) begin
        acqBusy_ff <= 1'b0;
        convSeen_ff <= 1'b0;
        filtSeen_ff <= 1'b0;
        filterRun <= 1'b0;
      end else if (acqGo) begin
        acqBusy_ff <= 1'b1;
        filterRun <= 1'b1;
      end else if (acqBusy_ff) begin
        convSeen_ff <= convSeen_ff || convDone;
        filtSeen_ff <= filtSeen_ff || filtDone;
      end
    end
  end

  // ---------------------------------------------------------------
  // wake timer
  // ---------------------------------------------------------------
  cmm_timer_if #(.PW(TMR_W)) tif ();
  assign tif.run = state_ff == ST_ACTIVE;
  assign tif.activate = timerActivate;
  assign tif.restart = timerRestart;
  assign tif.periodWe = timerPeriodWe;
  assign tif.period = timerPeriod;

  cmm_wake_timer u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .clkEn(clkEn),
    .tif(tif)
  );

  // ---------------------------------------------------------------
  // pending events and interrupt; a new event wins over the ack
  // ---------------------------------------------------------------
  logic timerPend_ff, nxt_dataReady, nxt_timerPend;
  assign nxt_dataReady = runOk &&
    (acqEnd || (dataReady && !statusRead));
  assign nxt_timerPend = runOk &&
    (tif.tick || (timerPend_ff && !statusRead));
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dataReady <= 1'b0;
      timerPend_ff <= 1'b0;
      irq <= 1'b0;
    end else if (clkEn) begin
      dataReady <= nxt_dataReady;
      timerPend_ff <= nxt_timerPend;
      irq <= nxt_dataReady || nxt_timerPend;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_sleep_all_off: assert property (
    @(posedge mclk) disable iff (!rstn)
    state_ff == ST_SLEEP |-> !analogInternalSupplyEn &&
      !digitalInternalSupplyEn && !mcuSupplyOutEn && !irq && !convStart)
    else $error("block powered while asleep");
  chk_wake_on_rise: assert property (
    @(posedge mclk) disable iff (!rstn)
    clkEn && state_ff == ST_SLEEP && sleepS2_ff |=>
      state_ff == ST_PWRUP && analogInternalSupplyEn)
    else $error("no wake-up after sleep control rise");
  chk_chain_follow: assert property (
    @(posedge mclk) disable iff (!rstn)
    clkEn |=> sleepControlChainOut == $past(sleepS2_ff))
    else $error("chain output not following mode");
  chk_mcu_gate: assert property (
    @(posedge mclk) disable iff (!rstn)
    mcuSupplyOutEn |-> analogInternalSupplyEn && $past(regEnS2_ff))
    else $error("mcu supply on without regulator enable");
  chk_cfg_defaults: assert property (
    @(posedge mclk) disable iff (!rstn)
    $rose(activeMode) |-> $past(cfgDefaultLoad))
    else $error("active mode entered without default load");
  chk_acq_start: assert property (
    @(posedge mclk) disable iff (!rstn)
    clkEn && acqGo |=> convStart && filterRun)
    else $error("acquisition request not started");
  chk_data_irq: assert property (
    @(posedge mclk) disable iff (!rstn)
    clkEn && acqEnd |=> dataReady && irq)
    else $error("data ready not raised after filtering");
  chk_irq_hold: assert property (
    @(posedge mclk) disable iff (!rstn)
    clkEn && irq && !statusRead && runOk |=> irq)
    else $error("irq dropped without status read");
  chk_wake_time: assert property (
    @(posedge mclk) disable iff (!rstn)
    state_ff == ST_PWRUP |-> cnt_ff <= CNT_W'(PWR_UP_CYC - 1))
    else $error("wake-up exceeds limit");
  chk_sleep_time: assert property (
    @(posedge mclk) disable iff (!rstn)
    state_ff == ST_PWRDN |-> cnt_ff <= CNT_W'(PWR_DN_CYC - 1))
    else $error("power-down exceeds limit");
  cov_wake_done: cover property (@(posedge mclk) disable iff (!rstn)
    $rose(activeMode));
  cov_acq_irq: cover property (@(posedge mclk) disable iff (!rstn)
    acqEnd ##1 irq);
  cov_ack: cover property (@(posedge mclk) disable iff (!rstn)
    irq && statusRead ##1 !irq);
endmodule // cmm_mode_control

// [verilog/cmm_pkg.sv]
// package: mode control timing constants, state encoding and widths
package cmm_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned T_WAKE_MAX_MS = 3;
  localparam int unsigned T_SLEEP_MAX_MS = 10;
  // cycles per millisecond first, so no product leaves 32 bits
  localparam int unsigned CYC_PER_MS = 1000000000 / CLK_PERIOD_PS;
  localparam int unsigned WAKE_CYC = T_WAKE_MAX_MS * CYC_PER_MS;
  localparam int unsigned SLEEP_CYC = T_SLEEP_MAX_MS * CYC_PER_MS;
  localparam int unsigned CNT_W = 21;
  // ---------------------------------------------------------------
  // wake timer
  // ---------------------------------------------------------------
  localparam int unsigned TMR_W = 16;
  localparam logic [TMR_W-1:0] TMR_PERIOD_RST = 16'hFFFF;
  // ---------------------------------------------------------------
  // mode sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SLEEP  = 3'b000,
    ST_PWRUP  = 3'b001,
    ST_LOAD   = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_PWRDN  = 3'b100
  } cmm_state_t;
endpackage

// [verilog/cmm_timer_if.sv]
// interface: carrier between the sequencer and the wake timer
`timescale 1ns/10ps
interface cmm_timer_if #(parameter int unsigned PW = 16);
  logic run;
  logic activate;
  logic restart;
  logic periodWe;
  logic [PW-1:0] period;
  logic tick;
  modport ctl (output run, activate, restart, periodWe, period,
               input tick);
  modport tmr (input run, activate, restart, periodWe, period,
               output tick);
endinterface

// [verilog/cmm_wake_timer.sv]
// wake timer: free running periodic tick once activated
`timescale 1ns/10ps
module cmm_wake_timer
  import cmm_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  cmm_timer_if.tmr tif
);
  logic active_ff;
  logic [TMR_W-1:0] cnt_ff;
  logic [TMR_W-1:0] period_ff;
  logic tick_ff;
  logic wrap;

  assign wrap = active_ff && (cnt_ff >= period_ff);
  assign tif.tick = tick_ff;

  // ---------------------------------------------------------------
  // activation: only leaving active mode stops it
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      active_ff <= 1'b0;
    end else if (clkEn) begin
      if (!tif.run) begin
        active_ff <= 1'b0;
      end else if (tif.activate) begin
        active_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // period, reprogrammable on the fly
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      period_ff <= TMR_PERIOD_RST;
    end else if (clkEn) begin
      if (!tif.run) begin
        period_ff <= TMR_PERIOD_RST;
      end else if (tif.periodWe) begin
        period_ff <= tif.period;
      end
    end
  end

  // ---------------------------------------------------------------
  // counter and tick
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (clkEn) begin
      tick_ff <= wrap && tif.run;
      if (!tif.run || tif.restart || wrap || !active_ff) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + TMR_W'(1);
      end
    end
  end

  chk_timer_restart: assert property (
    @(posedge mclk) disable iff (!rstn)
    clkEn && tif.restart |=> cnt_ff == '0)
    else $error("wake timer not cleared by restart");
  chk_timer_unstoppable: assert property (
    @(posedge mclk) disable iff (!rstn)
    active_ff && tif.run |=> active_ff)
    else $error("wake timer stopped while active");
  chk_timer_tick: assert property (
    @(posedge mclk) disable iff (!rstn)
    clkEn && tif.run && active_ff && cnt_ff >= period_ff
    |=> tick_ff ##1 !tick_ff || !clkEn)
    else $error("wake timer tick missing at period end");
  cov_timer_tick: cover property (@(posedge mclk) disable iff (!rstn)
    tick_ff);
endmodule // cmm_wake_timer
